// *** src/tdc_ctrl_pkg.sv ***
package tdc_ctrl_pkg;

  // register offsets inside the module window (byte addresses, 16-bit registers)
  localparam logic [15:0] OFF_MODULE_CONFIG = 16'h1000;
  localparam logic [15:0] OFF_MODULE_FLAGS = 16'h1002;
  localparam logic [15:0] OFF_ADDR_RELOC_HIGH = 16'h1004;
  localparam logic [15:0] OFF_ADDR_RELOC_LOW = 16'h1006;
  localparam logic [15:0] OFF_ADDR_RELOC_SELECT = 16'h1008;
  localparam logic [15:0] OFF_IRQ_PRIORITY = 16'h100A;
  localparam logic [15:0] OFF_IRQ_ID_BYTE = 16'h100C;
  localparam logic [15:0] OFF_SLOT_POSITION = 16'h100E;

  // module_config field positions
  localparam int CFG_BUS_FAULT_ENABLE = 0;
  localparam int CFG_LINE_LOAD = 1;
  localparam int CFG_LINE_LOAD_SOURCE = 2;
  localparam int CFG_VOID_FRAME = 3;
  localparam int CFG_PAD_ODD = 4;
  localparam int CFG_COMPENSATION = 5;
  localparam int CFG_BUFFER_TEST = 6;
  localparam int CFG_READ_COMP_SRAM = 7;
  localparam int CFG_EVENT_LEN_QUEUE = 8;
  localparam int CFG_LONG_TIME_STAMP_ON = 9;
  localparam logic [15:0] CFG_WRITE_MASK = 16'h03FF;
  localparam logic [15:0] CFG_RESET = 16'h0020;

  // module_flags field positions
  localparam int FLG_OUTPUT_HAS_DATA = 0;
  localparam int FLG_ALMOST_FULL = 1;
  localparam int FLG_FULL = 2;
  localparam int FLG_TRIG_MATCH = 3;
  localparam int FLG_HEADER_EN = 4;
  localparam int FLG_LINE_LOAD_ON = 5;
  localparam int FLG_TDC_ERROR = 6;
  localparam int FLG_BUS_FAULT_SEEN = 10;
  localparam int FLG_DRAINED = 11;
  localparam int FLG_LSB_RESOLUTION = 12;
  localparam int FLG_PAIR_MODE = 14;
  localparam int FLG_TRIGGER_DROPPED = 15;

  // other register widths and reset values
  localparam logic [7:0] RELOC_RESET = 8'h00;
  localparam logic [2:0] IRQ_PRIORITY_RESET = 3'h0;
  localparam logic [7:0] IRQ_ID_BYTE_RESET = 8'hDD;
  localparam logic [4:0] SLOT_NUMBER_RESET = 5'h1F;

  // output buffer figures
  localparam logic [15:0] FULL_LEVEL = 16'h7FDF;
  localparam logic [31:0] FILLER_WORD = 32'hC000_0000;
  localparam int GROUPS = 4;
  localparam int ERR_SIZE_LIMIT = 12;
  localparam int ERR_TRIG_FIFO = 13;
  localparam int ERR_FATAL = 14;

  // register port request and answer
  typedef struct packed {
    logic stb;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } reg_rsp_t;

  // output buffer read port, one D32 word per strobe
  typedef struct packed {
    logic stb;
    logic block;
    logic [31:0] word;
    logic wordValid;
  } buf_req_t;

  typedef struct packed {
    logic ack;
    logic busFault;
    logic [31:0] data;
  } buf_rsp_t;

  // whole state of the bank
  typedef struct packed {
    logic [15:0] cfg;
    logic [7:0] relocHigh;
    logic [7:0] relocLow;
    logic relocSelect;
    logic [2:0] irqLevel;
    logic [7:0] irqId;
    logic [4:0] slotNumber;
    logic busFaultSeen;
    logic triggerDropped;
    logic cbltSentAll;
    reg_rsp_t regRsp;
    buf_rsp_t bufRsp;
    logic iackAck;
    logic [7:0] iackData;
    logic [14:0] errorWord;
    logic evLenPush;
    logic [31:0] evLenWord;
    logic frameWrite;
  } state_t;

  localparam state_t STATE_RESET = '{
    cfg: CFG_RESET,
    relocHigh: RELOC_RESET,
    relocLow: RELOC_RESET,
    relocSelect: 1'b0,
    irqLevel: IRQ_PRIORITY_RESET,
    irqId: IRQ_ID_BYTE_RESET,
    slotNumber: SLOT_NUMBER_RESET,
    default: '0
  };

endpackage : tdc_ctrl_pkg

// *** src/tdc_readout_control_status.sv ***
// Behaviour
// RQ1 - error word holds three flags per hit group: fifo loss, L1 loss, hit error
// RQ2 - error bits 12, 13, 14: size-limit reject, trigger fifo loss, fatal chip error
// RQ3 - filler word with top bits 11000 pads block reads and empty buffer reads
// RQ4 - fault enable clear always acknowledges; set ends blocks and empty D32 with fault
// RQ5 - software line load only counts with source bit set, else board switch decides
// RQ6 - trigger without data writes header and trailer only when void-frame bit set
// RQ7 - padding enabled adds one invalid word to odd events in 32-bit block reads
// RQ8 - compensation applied while its bit is set; bit resets to one
// RQ9 - buffer test mode only while its bit is set; bit resets to zero
// RQ10 - event-length queue pushes counter and word count per event while enabled
// RQ11 - extended time tag word inserted only while long time stamp bit set
// RQ12 - data flag: one whole event in matching mode, any word in continuous mode
// RQ13 - almost full flag set when word count reaches the programmed level
// RQ14 - full flag set at capacity minus 33 words
// RQ15 - bus fault seen sets on generated fault, clears on status read
// RQ16 - drained flag when empty, or all sent in chained block until chain ends
// RQ17 - two-bit resolution field reports the measurement lsb code
// RQ18 - trigger dropped sets on any lost trigger, clears on status read
// RQ19 - base address from relocation registers when select set, else from switches
// RQ20 - interrupt level in three low bits, reset zero, zero disables interrupts
// RQ21 - acknowledge cycle returns interrupt id byte, reset 0xDD, upper bits ignored
// RQ22 - five slot bits reset to ones and feed header and trailer words
// RQ23 - all registers take 16-bit accesses and ignore writes to reserved bits
`timescale 1ns/100ps

module tdc_readout_control_status (
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire tdc_ctrl_pkg::reg_req_t regReq,
  output tdc_ctrl_pkg::reg_rsp_t regRsp,
  // output buffer read port
  input wire tdc_ctrl_pkg::buf_req_t bufReq,
  output tdc_ctrl_pkg::buf_rsp_t bufRsp,
  // chained block transfer context
  input wire logic cbltActive,
  input wire logic cbltEnd,
  // output buffer state
  input wire logic [15:0] bufWordCount,
  input wire logic [15:0] bufEventCount,
  input wire logic [15:0] almostFullLevel,
  // device state reported in the flags
  input wire logic trigMatchMode,
  input wire logic headerEnable,
  input wire logic [3:0] tdcError,
  input wire logic [1:0] lsbResolution,
  input wire logic pairMode,
  input wire logic triggerLost,
  input wire logic termSwitchOn,
  // base address switches, bits 31 to 16
  input wire logic [15:0] rotarySwitch,
  // tdc error sources
  input wire logic [3:0] groupFifoLost,
  input wire logic [3:0] groupL1Lost,
  input wire logic [3:0] groupHitError,
  input wire logic sizeLimitReject,
  input wire logic trigFifoLost,
  input wire logic fatalChipError,
  // event assembly context
  input wire logic emptyTrigger,
  input wire logic eventWritten,
  input wire logic [15:0] eventCounter,
  input wire logic [15:0] eventWords,
  input wire logic blt32Mode,
  // interrupt acknowledge
  input wire logic iackStb,
  input wire logic [2:0] iackLevel,
  output logic iackAck,
  output logic [7:0] iackData,
  // control results
  output logic lineLoadOn,
  output logic compensationOn,
  output logic bufferTestMode,
  output logic compSramReadable,
  output logic longTimeStampOn,
  output logic padOddEvent,
  output logic frameWrite,
  output logic evLenPush,
  output logic [31:0] evLenWord,
  output logic [14:0] errorWord,
  output logic [15:0] baseAddress,
  output logic irqEnable,
  output logic [2:0] irqLevel,
  output logic [4:0] slotNumber
);

  tdc_ctrl_pkg::state_t st;
  tdc_ctrl_pkg::state_t next_st;

  logic regRead;
  logic regWrite;
  logic cfgWrite;
  logic flagsRead;
  logic bufEmpty;
  logic outputHasData;
  logic almostFull;
  logic bufFull;
  logic drained;
  logic faultNow;
  logic [15:0] flags;
  logic [15:0] readData;
  logic [14:0] errorNext;

  // one decoder for every register, used by reads and writes alike
  function automatic logic regHit(input logic [15:0] addr, input logic [15:0] offset);
    regHit = (addr == offset);
  endfunction : regHit

  assign regRead = regReq.stb && !regReq.write;
  assign regWrite = regReq.stb && regReq.write;
  assign cfgWrite = regWrite && regHit(regReq.addr, tdc_ctrl_pkg::OFF_MODULE_CONFIG);
  assign flagsRead = regRead && regHit(regReq.addr, tdc_ctrl_pkg::OFF_MODULE_FLAGS);

  // buffer level flags
  assign bufEmpty = (bufWordCount == 16'h0000);
  assign outputHasData = trigMatchMode ? (bufEventCount != 16'h0000) : !bufEmpty; // RQ12
  assign almostFull = (bufWordCount >= almostFullLevel); // RQ13
  assign bufFull = (bufWordCount >= tdc_ctrl_pkg::FULL_LEVEL); // RQ14
  assign drained = bufEmpty || st.cbltSentAll; // RQ16

  // a fault is raised only when enabled, and only for an exhausted read
  always_comb begin
    faultNow = 1'b0;
    if (bufReq.stb && !bufReq.wordValid && st.cfg[tdc_ctrl_pkg::CFG_BUS_FAULT_ENABLE]) begin
      faultNow = 1'b1; // RQ4
    end
  end

  // flags word as software sees it
  always_comb begin
    flags = 16'h0000;
    flags[tdc_ctrl_pkg::FLG_OUTPUT_HAS_DATA] = outputHasData;
    flags[tdc_ctrl_pkg::FLG_ALMOST_FULL] = almostFull;
    flags[tdc_ctrl_pkg::FLG_FULL] = bufFull;
    flags[tdc_ctrl_pkg::FLG_TRIG_MATCH] = trigMatchMode;
    flags[tdc_ctrl_pkg::FLG_HEADER_EN] = headerEnable;
    flags[tdc_ctrl_pkg::FLG_LINE_LOAD_ON] = lineLoadOn;
    flags[tdc_ctrl_pkg::FLG_TDC_ERROR +: 4] = tdcError;
    flags[tdc_ctrl_pkg::FLG_BUS_FAULT_SEEN] = st.busFaultSeen; // RQ15
    flags[tdc_ctrl_pkg::FLG_DRAINED] = drained; // RQ16
    flags[tdc_ctrl_pkg::FLG_LSB_RESOLUTION +: 2] = lsbResolution; // RQ17
    flags[tdc_ctrl_pkg::FLG_PAIR_MODE] = pairMode;
    flags[tdc_ctrl_pkg::FLG_TRIGGER_DROPPED] = st.triggerDropped; // RQ18
  end

  // read multiplexer; the write-only select register and unknown offsets read zero
  always_comb begin
    readData = 16'h0000;
    if (regHit(regReq.addr, tdc_ctrl_pkg::OFF_MODULE_CONFIG)) begin
      readData = st.cfg;
    end else if (regHit(regReq.addr, tdc_ctrl_pkg::OFF_MODULE_FLAGS)) begin
      readData = flags;
    end else if (regHit(regReq.addr, tdc_ctrl_pkg::OFF_ADDR_RELOC_HIGH)) begin
      readData = {8'h00, st.relocHigh};
    end else if (regHit(regReq.addr, tdc_ctrl_pkg::OFF_ADDR_RELOC_LOW)) begin
      readData = {8'h00, st.relocLow};
    end else if (regHit(regReq.addr, tdc_ctrl_pkg::OFF_IRQ_PRIORITY)) begin
      readData = {13'h0000, st.irqLevel};
    end else if (regHit(regReq.addr, tdc_ctrl_pkg::OFF_IRQ_ID_BYTE)) begin
      readData = {8'h00, st.irqId};
    end else if (regHit(regReq.addr, tdc_ctrl_pkg::OFF_SLOT_POSITION)) begin
      readData = {11'h000, st.slotNumber};
    end
  end

  // error word: three flags per hit group, then the chip-wide flags
  generate
    for (genvar g = 0; g < tdc_ctrl_pkg::GROUPS; g++) begin : gGroupFlags
      assign errorNext[3*g] = groupFifoLost[g]; // RQ1
      assign errorNext[3*g+1] = groupL1Lost[g]; // RQ1
      assign errorNext[3*g+2] = groupHitError[g]; // RQ1
    end
  endgenerate
  assign errorNext[tdc_ctrl_pkg::ERR_SIZE_LIMIT] = sizeLimitReject; // RQ2
  assign errorNext[tdc_ctrl_pkg::ERR_TRIG_FIFO] = trigFifoLost; // RQ2
  assign errorNext[tdc_ctrl_pkg::ERR_FATAL] = fatalChipError; // RQ2

  // next state of the whole bank
  always_comb begin
    next_st = st;
    next_st.regRsp.ack = 1'b0;
    next_st.bufRsp.ack = 1'b0;
    next_st.bufRsp.busFault = 1'b0;
    next_st.iackAck = 1'b0;
    next_st.evLenPush = 1'b0;
    next_st.frameWrite = 1'b0;
    next_st.errorWord = errorNext;

    // register writes; only the defined bits of each register are kept
    if (cfgWrite) begin
      next_st.cfg = regReq.wdata & tdc_ctrl_pkg::CFG_WRITE_MASK; // RQ23
    end
    if (regWrite && regHit(regReq.addr, tdc_ctrl_pkg::OFF_ADDR_RELOC_HIGH)) begin
      next_st.relocHigh = regReq.wdata[7:0]; // RQ19
    end
    if (regWrite && regHit(regReq.addr, tdc_ctrl_pkg::OFF_ADDR_RELOC_LOW)) begin
      next_st.relocLow = regReq.wdata[7:0]; // RQ19
    end
    if (regWrite && regHit(regReq.addr, tdc_ctrl_pkg::OFF_ADDR_RELOC_SELECT)) begin
      next_st.relocSelect = regReq.wdata[0]; // RQ19
    end
    if (regWrite && regHit(regReq.addr, tdc_ctrl_pkg::OFF_IRQ_PRIORITY)) begin
      next_st.irqLevel = regReq.wdata[2:0]; // RQ20
    end
    if (regWrite && regHit(regReq.addr, tdc_ctrl_pkg::OFF_IRQ_ID_BYTE)) begin
      next_st.irqId = regReq.wdata[7:0]; // RQ21
    end
    if (regWrite && regHit(regReq.addr, tdc_ctrl_pkg::OFF_SLOT_POSITION)) begin
      next_st.slotNumber = regReq.wdata[4:0]; // RQ22
    end

    // every register access is answered one cycle later, unknown reads give zero
    if (regReq.stb) begin
      next_st.regRsp.ack = 1'b1; // RQ23
      next_st.regRsp.rdata = regRead ? readData : 16'h0000;
    end

    // sticky flags: a status read clears them, a new event in the same cycle wins
    if (flagsRead) begin
      next_st.busFaultSeen = 1'b0; // RQ15
      next_st.triggerDropped = 1'b0; // RQ18
    end
    if (faultNow) begin
      next_st.busFaultSeen = 1'b1; // RQ15
    end
    if (triggerLost) begin
      next_st.triggerDropped = 1'b1; // RQ18
    end

    // buffer read: data, filler when nothing is there, or a fault when enabled
    if (bufReq.stb) begin
      if (bufReq.wordValid) begin
        next_st.bufRsp.ack = 1'b1;
        next_st.bufRsp.data = bufReq.word;
      end else if (faultNow) begin
        next_st.bufRsp.busFault = 1'b1; // RQ4
        next_st.bufRsp.data = tdc_ctrl_pkg::FILLER_WORD;
      end else begin
        next_st.bufRsp.ack = 1'b1; // RQ4
        next_st.bufRsp.data = tdc_ctrl_pkg::FILLER_WORD; // RQ3
      end
    end

    // during a chained block the board stays drained once it ran out of words
    if (cbltActive && bufReq.stb && !bufReq.wordValid) begin
      next_st.cbltSentAll = 1'b1; // RQ16
    end
    if (cbltEnd) begin
      next_st.cbltSentAll = 1'b0; // RQ16
    end

    // interrupt acknowledge: answer only for our own nonzero level
    if (iackStb && (st.irqLevel != 3'h0) && (iackLevel == st.irqLevel)) begin
      next_st.iackAck = 1'b1; // RQ21
      next_st.iackData = st.irqId; // RQ21
    end

    // event assembly side effects
    if (emptyTrigger && st.cfg[tdc_ctrl_pkg::CFG_VOID_FRAME]) begin
      next_st.frameWrite = 1'b1; // RQ6
    end
    if (eventWritten && st.cfg[tdc_ctrl_pkg::CFG_EVENT_LEN_QUEUE]) begin
      next_st.evLenPush = 1'b1; // RQ10
      next_st.evLenWord = {eventCounter, eventWords}; // RQ10
    end
  end

  // single state register; reset loads constants only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= tdc_ctrl_pkg::STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // answers come straight from the state register
  assign regRsp = st.regRsp;
  assign bufRsp = st.bufRsp;
  assign iackAck = st.iackAck;
  assign iackData = st.iackData;
  assign errorWord = st.errorWord;
  assign evLenPush = st.evLenPush;
  assign evLenWord = st.evLenWord;
  assign frameWrite = st.frameWrite;

  // the software line-load bit is ignored unless software owns the terminations
  assign lineLoadOn = st.cfg[tdc_ctrl_pkg::CFG_LINE_LOAD_SOURCE]
    ? st.cfg[tdc_ctrl_pkg::CFG_LINE_LOAD] : termSwitchOn; // RQ5

  // control bits steering the rest of the readout
  assign compensationOn = st.cfg[tdc_ctrl_pkg::CFG_COMPENSATION]; // RQ8
  assign bufferTestMode = st.cfg[tdc_ctrl_pkg::CFG_BUFFER_TEST]; // RQ9
  assign compSramReadable = st.cfg[tdc_ctrl_pkg::CFG_READ_COMP_SRAM];
  assign longTimeStampOn = st.cfg[tdc_ctrl_pkg::CFG_LONG_TIME_STAMP_ON]; // RQ11
  // padding only matters for 32-bit block reads of an odd-length event
  assign padOddEvent = st.cfg[tdc_ctrl_pkg::CFG_PAD_ODD] && blt32Mode
    && eventWords[0]; // RQ7

  // base address: relocation takes effect at once, old address stops answering
  assign baseAddress = st.relocSelect ? {st.relocHigh, st.relocLow} : rotarySwitch; // RQ19

  // interrupt level zero means no interrupts at all
  assign irqLevel = st.irqLevel;
  assign irqEnable = (st.irqLevel != 3'h0); // RQ20
  assign slotNumber = st.slotNumber; // RQ22

endmodule : tdc_readout_control_status

// *** bench/tdc_ctrl_checker.sv ***
`timescale 1ns/100ps

// watches the bank from its ports only
module tdc_ctrl_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire tdc_ctrl_pkg::reg_req_t regReq,
  input wire tdc_ctrl_pkg::reg_rsp_t regRsp,
  input wire tdc_ctrl_pkg::buf_req_t bufReq,
  input wire tdc_ctrl_pkg::buf_rsp_t bufRsp,
  input wire logic [15:0] bufWordCount,
  input wire logic [15:0] almostFullLevel,
  input wire logic [3:0] groupFifoLost,
  input wire logic [3:0] groupL1Lost,
  input wire logic [3:0] groupHitError,
  input wire logic sizeLimitReject,
  input wire logic trigFifoLost,
  input wire logic fatalChipError,
  input wire logic [15:0] eventCounter,
  input wire logic [15:0] eventWords,
  input wire logic blt32Mode,
  input wire logic padOddEvent,
  input wire logic evLenPush,
  input wire logic [31:0] evLenWord,
  input wire logic [14:0] errorWord,
  input wire logic iackStb,
  input wire logic [2:0] iackLevel,
  input wire logic iackAck,
  input wire logic [2:0] irqLevel,
  input wire logic irqEnable
);
  logic [14:0] expErr;
  logic [14:0] lastErr;

  // three flags per group from bit 0 up, chip-wide flags on top
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      expErr[3 * g +: 3] = {groupHitError[g], groupL1Lost[g], groupFifoLost[g]};
    end
    expErr[14:12] = {fatalChipError, trigFifoLost, sizeLimitReject};
  end

  // one cycle of delay, matching the registered error word
  always_ff @(posedge clk) begin
    lastErr <= expErr;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // status read and empty buffer read, as taken at the port
  sequence flagsRead;
    regReq.stb && !regReq.write && regReq.addr == tdc_ctrl_pkg::OFF_MODULE_FLAGS;
  endsequence
  sequence emptyRead;
    bufReq.stb && !bufReq.wordValid;
  endsequence

  chk_reg_answer: assert property (regReq.stb |=> regRsp.ack)
    else $error("register access unanswered");
  chk_buf_single: assert property (bufReq.stb |=> bufRsp.ack != bufRsp.busFault)
    else $error("buffer read needs one termination");
  chk_buf_data: assert property (bufReq.stb && bufReq.wordValid |=>
    bufRsp.ack && bufRsp.data == $past(bufReq.word))
    else $error("buffer word lost");
  chk_filler_word: assert property (emptyRead |=> bufRsp.data[31:27] == 5'h18)
    else $error("filler code wrong");
  chk_group_flags: assert property ($past(rst_n) |-> errorWord[11:0] == lastErr[11:0])
    else $error("group error flags wrong");
  chk_chip_flags: assert property ($past(rst_n) |-> errorWord[14:12] == lastErr[14:12])
    else $error("chip error flags wrong");
  chk_full_flag: assert property (flagsRead |=>
    regRsp.rdata[tdc_ctrl_pkg::FLG_FULL] == ($past(bufWordCount) >= 16'h7FDF))
    else $error("full flag wrong");
  chk_almost_full: assert property (flagsRead |=>
    regRsp.rdata[1] == ($past(bufWordCount) >= $past(almostFullLevel)))
    else $error("almost full flag wrong");
  chk_event_length: assert property (evLenPush |->
    evLenWord == {$past(eventCounter), $past(eventWords)})
    else $error("event length word wrong");
  chk_pad_odd: assert property (padOddEvent |-> blt32Mode && eventWords[0])
    else $error("padding on even event");
  chk_irq_zero: assert property (irqLevel == 3'h0 |-> !irqEnable)
    else $error("level zero still enabled");
  chk_iack_answer: assert property (
    iackStb && irqLevel != 3'h0 && iackLevel == irqLevel |=> iackAck)
    else $error("acknowledge cycle unanswered");
endmodule : tdc_ctrl_checker

bind tdc_readout_control_status tdc_ctrl_checker i_chk (.*);

// *** bench/vme_host_model.sv ***
`timescale 1ns/100ps

// bus master: one strobe per call; released lines show the inverse, except buffer block and valid which drop to zero, so stale values never pass
module vme_host_model (
  input wire logic clk,
  output tdc_ctrl_pkg::reg_req_t regReq,
  input wire tdc_ctrl_pkg::reg_rsp_t regRsp,
  output tdc_ctrl_pkg::buf_req_t bufReq,
  input wire tdc_ctrl_pkg::buf_rsp_t bufRsp
);
  initial begin
    regReq = '0;
    bufReq = '0;
  end

  // register access, answer taken one cycle after the strobe
  task automatic reg_io(input logic wr, input logic [15:0] a, input logic [15:0] d,
      output tdc_ctrl_pkg::reg_rsp_t r);
    @(posedge clk);
    regReq <= '{1'h1, wr, a, d};
    @(posedge clk);
    regReq <= '{1'h0, ~wr, ~a, ~d};
    #1 r = regRsp;
  endtask : reg_io

  // one block-mode buffer read of a single word
  task automatic buf_rd(input logic v, input logic [31:0] w, output tdc_ctrl_pkg::buf_rsp_t r);
    @(posedge clk);
    bufReq <= '{1'h1, 1'h1, w, v};
    @(posedge clk);
    bufReq <= '{1'h0, 1'h0, ~w, 1'h0};
    #1 r = bufRsp;
  endtask : buf_rd
endmodule : vme_host_model

// *** bench/tb_top.sv ***
`timescale 1ns/100ps

// shadow registers and a flag model beside the bank
module tb_top;
  localparam logic [15:0] WR_MASK [9] = '{16'h03FF, 16'h0000, 16'h00FF, 16'h00FF, 16'h0000,
    16'h0007, 16'h00FF, 16'h001F, 16'h0000};
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  tdc_ctrl_pkg::reg_req_t regReq;
  tdc_ctrl_pkg::reg_rsp_t regRsp;
  tdc_ctrl_pkg::buf_req_t bufReq;
  tdc_ctrl_pkg::buf_rsp_t bufRsp;
  logic cbltActive, cbltEnd, trigMatchMode, headerEnable, pairMode, triggerLost, termSwitchOn;
  logic sizeLimitReject, trigFifoLost, fatalChipError, emptyTrigger, eventWritten, blt32Mode;
  logic iackStb, iackAck, lineLoadOn, compensationOn, bufferTestMode, compSramReadable;
  logic longTimeStampOn, padOddEvent, frameWrite, evLenPush, irqEnable;
  logic [1:0] lsbResolution;
  logic [2:0] iackLevel, irqLevel;
  logic [3:0] tdcError, groupFifoLost, groupL1Lost, groupHitError;
  logic [4:0] slotNumber;
  logic [7:0] iackData;
  logic [14:0] errorWord;
  logic [15:0] bufWordCount, bufEventCount, almostFullLevel, rotarySwitch, eventCounter;
  logic [15:0] eventWords, baseAddress;
  logic [31:0] evLenWord, w;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int shadow [9] = '{16'h0020, 0, 0, 0, 0, 0, 16'h00DD, 16'h001F, 0};
  int wcTab [4] = '{0, 32734, 32735, 32736};
  bit relocSel, faultSeen, trigDrop, drained;
  tdc_ctrl_pkg::reg_rsp_t r;
  tdc_ctrl_pkg::buf_rsp_t b;

  tdc_readout_control_status i_tdc_readout_control_status (.*);
  vme_host_model host (.*);

  always #2.5 clk = ~clk;

  // hang guard, far above the run's real length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask : check

  function automatic logic ll_model();
    return shadow[0][2] ? shadow[0][1] : termSwitchOn;
  endfunction : ll_model

  function automatic logic [15:0] flags_model();
    return {trigDrop, pairMode, lsbResolution, drained || bufWordCount == 16'h0000, faultSeen,
      tdcError, ll_model(), headerEnable, trigMatchMode, bufWordCount >= 16'h7FDF,
      bufWordCount >= almostFullLevel, trigMatchMode ? bufEventCount != 0 : bufWordCount != 0};
  endfunction : flags_model

  function automatic logic [14:0] err_model();
    logic [14:0] e;
    for (int g = 0; g < 4; g++) e[3 * g +: 3] = {groupHitError[g], groupL1Lost[g], groupFifoLost[g]};
    e[14:12] = {fatalChipError, trigFifoLost, sizeLimitReject};
    return e;
  endfunction : err_model

  // new level inputs; at time zero without waiting for an edge
  task automatic rnd(input bit now);
    if (!now) @(posedge clk);
    {trigMatchMode, headerEnable, tdcError, lsbResolution, pairMode, termSwitchOn, groupFifoLost,
      groupL1Lost, groupHitError, sizeLimitReject, trigFifoLost, fatalChipError,
      blt32Mode} <= 26'($urandom);
    {bufWordCount, bufEventCount} <= $urandom;
    {almostFullLevel, rotarySwitch} <= $urandom;
    {eventCounter, eventWords} <= $urandom;
  endtask : rnd

  // sticky status bits clear after every status read
  task automatic rd(input int i);
    logic [15:0] e;
    e = (i == 1) ? flags_model() : 16'(shadow[i]);
    host.reg_io(1'h0, 16'(16'h1000 + 2 * i), 16'h0000, r);
    check({r.ack, r.rdata}, {1'h1, e}, "read");
    if (i == 1) begin
      faultSeen = 0;
      trigDrop = 0;
    end
  endtask : rd

  task automatic wr(input int i, input logic [15:0] d);
    host.reg_io(1'h1, 16'(16'h1000 + 2 * i), d, r);
    check({r.ack, r.rdata}, {1'h1, 16'h0000}, "write");
    shadow[i] = d & WR_MASK[i];
    if (i == 4) relocSel = d[0];
  endtask : wr

  task automatic ports();
    check({irqLevel, slotNumber, irqEnable, compensationOn, bufferTestMode, longTimeStampOn,
      lineLoadOn, compSramReadable}, {3'(shadow[5]), 5'(shadow[7]), shadow[5] != 0,
      shadow[0][5], shadow[0][6], shadow[0][9], ll_model(), shadow[0][7]},
      "ctrl");
    check(baseAddress, relocSel ? {shadow[2][7:0], shadow[3][7:0]} : rotarySwitch, "base");
    check(errorWord, err_model(), "err");
  endtask : ports

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  initial begin
    {cbltActive, cbltEnd, triggerLost, emptyTrigger, eventWritten, iackStb, iackLevel} = '0;
    void'($urandom(32'hBCB66AEC));
    rnd(1'h1);
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    // reset values, unmapped place at the end
    for (int i = 0; i < 9; i++) rd(i);
    ports();
    $display("test reset done");
    // random writes over every place, reserved bits included
    repeat (20) begin
      rnd(1'h0);
      for (int i = 0; i < 9; i++) wr(i, 16'($urandom));
      for (int i = 0; i < 9; i++) rd(i);
      ports();
    end
    $display("test registers done");
    foreach (wcTab[k]) begin
      @(posedge clk);
      bufWordCount <= 16'(wcTab[k]);
      almostFullLevel <= 16'h7FDF;
      // let the new levels settle before the model reads them
      #1 rd(1);
    end
    $display("test levels done");
    // fault enable off and on, word present and absent
    for (int k = 0; k < 4; k++) begin
      wr(0, 16'(k >> 1));
      w = $urandom;
      host.buf_rd(k[0], w, b);
      check({b.ack, b.busFault, b.data}, {k[0] | !k[1], !k[0] & k[1],
        k[0] ? w : 32'hC000_0000}, "buf");
      if (!k[0] && k[1]) faultSeen = 1;
      @(posedge clk);
      triggerLost <= k[0];
      @(posedge clk);
      triggerLost <= 1'h0;
      trigDrop = k[0];
      rd(1);
    end
    // chained block: drained holds until the chain ends
    wr(7, 16'h0009);
    @(posedge clk);
    bufWordCount <= 16'h0010;
    cbltActive <= 1'h1;
    host.buf_rd(1'h0, 32'h0000_0000, b);
    check({b.ack, b.busFault}, 2'h1, "cblt");
    drained = 1;
    faultSeen = 1;
    rd(1);
    @(posedge clk);
    cbltEnd <= 1'h1;
    cbltActive <= 1'h0;
    @(posedge clk);
    cbltEnd <= 1'h0;
    drained = 0;
    rd(1);
    $display("test buffer done");
    // event side outputs with their enables off and on
    for (int k = 0; k < 2; k++) begin
      wr(0, k ? 16'h0318 : 16'h0020);
      rnd(1'h0);
      @(posedge clk);
      {eventWritten, emptyTrigger} <= 2'h3;
      @(posedge clk);
      {eventWritten, emptyTrigger} <= 2'h0;
      #1 check({evLenPush, frameWrite, padOddEvent},
        {k[0], k[0], k[0] & blt32Mode & eventWords[0]}, "evt");
      if (k == 1) check(evLenWord, {eventCounter, eventWords}, "len");
    end
    // acknowledge cycle at the wrong and the right level
    wr(5, 16'h0005);
    wr(6, 16'h12A5);
    for (int k = 4; k < 6; k++) begin
      @(posedge clk);
      iackStb <= 1'h1;
      iackLevel <= 3'(k);
      @(posedge clk);
      iackStb <= 1'h0;
      #1 check(iackAck, k == 5, "iack");
      if (k == 5) check(iackData, 8'hA5, "id");
    end
    $display("test events done");
    wrap_up();
  end
endmodule : tb_top
